// *** dcw_top.sv ***
`timescale 1ns/100ps
// Behaviour
// - Command and state words are 16 bits.
// - Bit 0 set: switch on, power enabled.
// - Bit 0 clear: ramp down, power off standstill.
// - Ramp stop interruptible, back to operating.
// - Bit 1 low: coast, inhibit, power off.
// - Bit 2 low: fast stop, then inhibit.
// - Fast stop completes, ignoring other commands.
// - Bit 3 set: enable pulses, run up.
// - Bit 3 clear: ramp zero, switched on.
// - Fault reset acts on bit 7 rise.
// - Reset after power loss goes inhibit.
// - Bit 10 selects bus commands and reference.
// - State bits 4-7: coast, fast, inhibit, warning.
// - State bits 8-10: tolerance, bus, reached.
// - State bit 0: ready to switch on.
// - State bit 3: error detected.
module dcw_top (
  input wire logic pclk, // Clock, 250 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic standstill_in, // Motor at standstill.
  input wire logic speed_tol_in, // Speed error within tolerance.
  input wire logic freq_reached_in, // Frequency reached or exceeded.
  input wire logic warning_in, // Warning present.
  input wire logic error_in, // Error detected.
  input wire logic error_power_off_in, // Error response removes power.
  output logic power_enable, // Power converter voltage on.
  output logic pulse_enable, // Output pulses on.
  output logic ramp_decel, // Decelerate along the ramp generator.
  output logic fast_decel, // Decelerate as fast as possible.
  output logic ramp_zero, // Ramp generator output forced to zero.
  output logic bus_control, // Commands and reference from the fieldbus.
  output logic [15:0] drive_state_word, // Returned state word.
  output logic irq // Interrupt, active high level.
);
  typedef struct packed {
    dcw_pkg::dcw_state_type state;
    dcw_pkg::dcw_state_type resume;
    logic pwr_removed;
    logic reset_bit_q;
    logic warn_q;
    logic [15:0] cmd;
    logic [15:0] local_cmd;
    logic [3:0] mask;
    logic [15:0] sw;
    logic power_en;
    logic pulse_en;
    logic ramp_decel;
    logic fast_decel;
    logic ramp_zero;
    logic bus_ctl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dcw_core_type;
  dcw_core_type r, n;

  logic [5:0] raw;
  logic [5:0] si;
  logic [15:0] eff;
  logic on_c, coast_c, fast_c, en_c, err_c, still_c;
  logic fault_edge;
  logic [3:0] ev;
  logic acc, done;
  logic [31:0] rd;
  logic rd_err;

  dcw_irq_if irq_bus();

  assign raw[dcw_pkg::IN_STANDSTILL] = standstill_in;
  assign raw[dcw_pkg::IN_SPEED_TOL] = speed_tol_in;
  assign raw[dcw_pkg::IN_FREQ] = freq_reached_in;
  assign raw[dcw_pkg::IN_WARN] = warning_in;
  assign raw[dcw_pkg::IN_ERROR] = error_in;
  assign raw[dcw_pkg::IN_ERR_PWR_OFF] = error_power_off_in;

  dcw_sync #(
    .W(dcw_pkg::IN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(raw),
    .dout(si)
  );

  dcw_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .bus(irq_bus)
  );

  // Software stands in for the local panel when the bus does not hold control.
  assign eff = r.cmd[dcw_pkg::CB_BUS] ? r.cmd : r.local_cmd;
  assign on_c = eff[dcw_pkg::CB_ON];
  assign coast_c = eff[dcw_pkg::CB_COAST_N];
  assign fast_c = eff[dcw_pkg::CB_FAST_N];
  assign en_c = eff[dcw_pkg::CB_ENABLE];
  assign err_c = si[dcw_pkg::IN_ERROR];
  assign still_c = si[dcw_pkg::IN_STANDSTILL];
  assign fault_edge = eff[dcw_pkg::CB_FAULT_RESET] & ~r.reset_bit_q;
  assign acc = psel & penable;
  assign done = acc & r.pready;

  always_comb
  begin
    n = r;
    ev = '0;
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    n.reset_bit_q = eff[dcw_pkg::CB_FAULT_RESET];
    n.warn_q = si[dcw_pkg::IN_WARN];
    if (err_c && r.state != dcw_pkg::ST_FAULT)
    begin
      n.state = dcw_pkg::ST_FAULT;
      n.resume = r.state;
      n.pwr_removed = si[dcw_pkg::IN_ERR_PWR_OFF];
    end
    else
    begin
      case (r.state)
        dcw_pkg::ST_INHIBIT:
        begin
          if (coast_c && fast_c && !on_c)
            n.state = dcw_pkg::ST_READY;
        end
        dcw_pkg::ST_READY:
        begin
          if (!coast_c || !fast_c)
            n.state = dcw_pkg::ST_INHIBIT;
          else if (on_c)
            n.state = dcw_pkg::ST_SWITCHED_ON;
        end
        dcw_pkg::ST_SWITCHED_ON:
        begin
          if (!coast_c || !fast_c)
            n.state = dcw_pkg::ST_INHIBIT;
          else if (!on_c)
            n.state = dcw_pkg::ST_READY;
          else if (en_c)
            n.state = dcw_pkg::ST_OPERATING;
        end
        dcw_pkg::ST_OPERATING:
        begin
          if (!coast_c)
            n.state = dcw_pkg::ST_INHIBIT;
          else if (!fast_c)
            n.state = dcw_pkg::ST_QUICK_STOP;
          else if (!on_c)
            n.state = dcw_pkg::ST_RAMP_STOP;
          else if (!en_c)
            n.state = dcw_pkg::ST_SWITCHED_ON;
        end
        dcw_pkg::ST_RAMP_STOP:
        begin
          if (!coast_c)
            n.state = dcw_pkg::ST_INHIBIT;
          else if (!fast_c)
            n.state = dcw_pkg::ST_QUICK_STOP;
          else if (on_c && en_c)
            n.state = dcw_pkg::ST_OPERATING;
          else if (!en_c || still_c)
            n.state = dcw_pkg::ST_READY;
        end
        dcw_pkg::ST_QUICK_STOP:
        begin
          // Commands are deliberately not looked at until standstill.
          if (still_c)
            n.state = dcw_pkg::ST_INHIBIT;
        end
        dcw_pkg::ST_FAULT:
        begin
          if (fault_edge && !err_c)
            n.state = r.pwr_removed ? dcw_pkg::ST_INHIBIT : r.resume;
        end
        default:
        begin
          n.state = dcw_pkg::ST_INHIBIT;
        end
      endcase
    end

    n.power_en = (n.state inside {dcw_pkg::ST_SWITCHED_ON, dcw_pkg::ST_OPERATING, dcw_pkg::ST_RAMP_STOP,
                  dcw_pkg::ST_QUICK_STOP}) || (n.state == dcw_pkg::ST_FAULT && !n.pwr_removed);
    n.pulse_en = n.state inside {dcw_pkg::ST_OPERATING, dcw_pkg::ST_RAMP_STOP, dcw_pkg::ST_QUICK_STOP};
    n.ramp_decel = n.state == dcw_pkg::ST_RAMP_STOP;
    n.fast_decel = n.state == dcw_pkg::ST_QUICK_STOP;
    n.ramp_zero = !n.pulse_en;
    n.bus_ctl = r.cmd[dcw_pkg::CB_BUS];

    // Bits 11 to 15 stay zero from this clear.
    n.sw = '0;
    n.sw[dcw_pkg::SB_READY_ON] = n.state inside {dcw_pkg::ST_READY, dcw_pkg::ST_SWITCHED_ON,
                                 dcw_pkg::ST_OPERATING, dcw_pkg::ST_RAMP_STOP};
    n.sw[dcw_pkg::SB_READY_OP] = n.state inside {dcw_pkg::ST_SWITCHED_ON, dcw_pkg::ST_OPERATING,
                                 dcw_pkg::ST_RAMP_STOP};
    n.sw[dcw_pkg::SB_OP_EN] = n.state == dcw_pkg::ST_OPERATING;
    n.sw[dcw_pkg::SB_FAULT] = n.state == dcw_pkg::ST_FAULT;
    n.sw[dcw_pkg::SB_COAST_OFF] = coast_c;
    n.sw[dcw_pkg::SB_FAST_OFF] = fast_c && n.state != dcw_pkg::ST_QUICK_STOP;
    n.sw[dcw_pkg::SB_INHIBIT] = n.state == dcw_pkg::ST_INHIBIT;
    n.sw[dcw_pkg::SB_WARN] = si[dcw_pkg::IN_WARN];
    n.sw[dcw_pkg::SB_SPEED_TOL] = si[dcw_pkg::IN_SPEED_TOL];
    n.sw[dcw_pkg::SB_BUS] = r.cmd[dcw_pkg::CB_BUS];
    n.sw[dcw_pkg::SB_FREQ] = si[dcw_pkg::IN_FREQ];

    ev[dcw_pkg::EV_STATE] = n.state != r.state;
    ev[dcw_pkg::EV_FAULT] = n.state == dcw_pkg::ST_FAULT && r.state != dcw_pkg::ST_FAULT;
    ev[dcw_pkg::EV_WARN] = si[dcw_pkg::IN_WARN] & ~r.warn_q;
    ev[dcw_pkg::EV_STOP] = (r.state inside {dcw_pkg::ST_RAMP_STOP, dcw_pkg::ST_QUICK_STOP}) && still_c
                           && n.state != r.state;

    case (paddr)
      dcw_pkg::OFS_CMD: rd[15:0] = r.cmd;
      dcw_pkg::OFS_LOCAL_CMD: rd[15:0] = r.local_cmd;
      dcw_pkg::OFS_STATE: rd[15:0] = r.sw;
      dcw_pkg::OFS_INT_STATUS: rd[3:0] = irq_bus.status;
      dcw_pkg::OFS_INT_MASK: rd[3:0] = r.mask;
      default: rd_err = 1'b1;
    endcase
    // One wait state: data and ready are both registered.
    n.pready = acc & ~r.pready;
    if (acc && !r.pready)
    begin
      n.prdata = pwrite ? 32'h0000_0000 : rd;
      n.pslverr = rd_err;
    end
    else if (done)
    begin
      n.prdata = 32'h0000_0000;
      n.pslverr = 1'b0;
    end
    if (done && pwrite)
    begin
      case (paddr)
        dcw_pkg::OFS_CMD: n.cmd = pwdata[15:0];
        dcw_pkg::OFS_LOCAL_CMD: n.local_cmd = pwdata[15:0];
        dcw_pkg::OFS_INT_MASK: n.mask = pwdata[3:0];
        default: n.mask = r.mask;
      endcase
    end
  end

  // Only the bits that the read returned are cleared.
  assign irq_bus.status_clr = (done && !pwrite && paddr == dcw_pkg::OFS_INT_STATUS) ? r.prdata[3:0] : 4'h0;
  assign irq_bus.event_set = ev;
  assign irq_bus.mask = r.mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.state <= dcw_pkg::ST_INHIBIT;
      r.resume <= dcw_pkg::ST_INHIBIT;
      r.cmd <= dcw_pkg::CMD_RESET;
      r.local_cmd <= dcw_pkg::CMD_RESET;
      r.mask <= dcw_pkg::MASK_RESET;
      r.sw <= dcw_pkg::SW_RESET;
      r.ramp_zero <= 1'b1;
    end
    else
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign power_enable = r.power_en;
  assign pulse_enable = r.pulse_en;
  assign ramp_decel = r.ramp_decel;
  assign fast_decel = r.fast_decel;
  assign ramp_zero = r.ramp_zero;
  assign bus_control = r.bus_ctl;
  assign drive_state_word = r.sw;
  assign irq = irq_bus.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ramp_enter;
    r.state == dcw_pkg::ST_OPERATING && !on_c && coast_c && fast_c && !err_c;
  endsequence
  sequence s_ramp_done;
    r.state == dcw_pkg::ST_RAMP_STOP && still_c && !on_c && coast_c && fast_c && !err_c;
  endsequence

  property p_reserved_zero;
    drive_state_word[15:11] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved state bits set");

  property p_coast;
    !coast_c && !err_c && r.state != dcw_pkg::ST_FAULT && r.state != dcw_pkg::ST_QUICK_STOP
      |=> r.state == dcw_pkg::ST_INHIBIT && !power_enable && !pulse_enable;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop did not cut power");

  property p_quick_hold;
    r.state == dcw_pkg::ST_QUICK_STOP && !still_c && !err_c |=> r.state == dcw_pkg::ST_QUICK_STOP && fast_decel;
  endproperty
  a_quick_hold: assert property (p_quick_hold) else $error("fast stop interrupted");

  property p_switch_on;
    r.state == dcw_pkg::ST_READY && on_c && coast_c && fast_c && !err_c
      |=> r.state == dcw_pkg::ST_SWITCHED_ON && power_enable;
  endproperty
  a_switch_on: assert property (p_switch_on) else $error("switch on failed");

  property p_enable;
    r.state == dcw_pkg::ST_SWITCHED_ON && on_c && en_c && coast_c && fast_c && !err_c
      |=> pulse_enable && !ramp_zero && drive_state_word[dcw_pkg::SB_OP_EN];
  endproperty
  a_enable: assert property (p_enable) else $error("enable operation failed");

  property p_disable;
    r.state == dcw_pkg::ST_OPERATING && on_c && !en_c && coast_c && fast_c && !err_c
      |=> r.state == dcw_pkg::ST_SWITCHED_ON && ramp_zero && power_enable;
  endproperty
  a_disable: assert property (p_disable) else $error("disable operation failed");

  property p_ramp_enter;
    s_ramp_enter |=> r.state == dcw_pkg::ST_RAMP_STOP && ramp_decel && power_enable;
  endproperty
  a_ramp_enter: assert property (p_ramp_enter) else $error("ramp stop not entered");

  property p_ramp_stop;
    s_ramp_done |=> r.state == dcw_pkg::ST_READY && !power_enable;
  endproperty
  a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop did not end in ready");

  property p_fault_hold;
    r.state == dcw_pkg::ST_FAULT && !fault_edge |=> r.state == dcw_pkg::ST_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault left without rising reset");

  property p_fault_inhibit;
    r.state == dcw_pkg::ST_FAULT && r.pwr_removed && fault_edge && !err_c
      |=> drive_state_word[dcw_pkg::SB_INHIBIT] && !drive_state_word[dcw_pkg::SB_FAULT];
  endproperty
  a_fault_inhibit: assert property (p_fault_inhibit) else $error("fault reset not inhibited");

  property p_bus_flag;
    drive_state_word[dcw_pkg::SB_BUS] == bus_control;
  endproperty
  a_bus_flag: assert property (p_bus_flag) else $error("bus flag mismatch");

  property p_ready_flag;
    drive_state_word[dcw_pkg::SB_READY_ON] == (r.state inside {dcw_pkg::ST_READY, dcw_pkg::ST_SWITCHED_ON,
      dcw_pkg::ST_OPERATING, dcw_pkg::ST_RAMP_STOP});
  endproperty
  a_ready_flag: assert property (p_ready_flag) else $error("ready flag mismatch");
endmodule

// *** dcw_pkg.sv ***
package dcw_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EV_W = 4;
  localparam int unsigned IN_W = 6;
  // Register byte offsets.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_LOCAL_CMD = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  // Command word bits.
  localparam int unsigned CB_ON = 0;
  localparam int unsigned CB_COAST_N = 1;
  localparam int unsigned CB_FAST_N = 2;
  localparam int unsigned CB_ENABLE = 3;
  localparam int unsigned CB_FAULT_RESET = 7;
  localparam int unsigned CB_BUS = 10;
  // State word bits.
  localparam int unsigned SB_READY_ON = 0;
  localparam int unsigned SB_READY_OP = 1;
  localparam int unsigned SB_OP_EN = 2;
  localparam int unsigned SB_FAULT = 3;
  localparam int unsigned SB_COAST_OFF = 4;
  localparam int unsigned SB_FAST_OFF = 5;
  localparam int unsigned SB_INHIBIT = 6;
  localparam int unsigned SB_WARN = 7;
  localparam int unsigned SB_SPEED_TOL = 8;
  localparam int unsigned SB_BUS = 9;
  localparam int unsigned SB_FREQ = 10;
  // Interrupt event bits.
  localparam int unsigned EV_STATE = 0;
  localparam int unsigned EV_FAULT = 1;
  localparam int unsigned EV_WARN = 2;
  localparam int unsigned EV_STOP = 3;
  // Drive input bits.
  localparam int unsigned IN_STANDSTILL = 0;
  localparam int unsigned IN_SPEED_TOL = 1;
  localparam int unsigned IN_FREQ = 2;
  localparam int unsigned IN_WARN = 3;
  localparam int unsigned IN_ERROR = 4;
  localparam int unsigned IN_ERR_PWR_OFF = 5;
  // Reset values.
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] SW_RESET = 16'h0040;
  localparam logic [3:0] MASK_RESET = 4'h0;
  typedef enum logic [2:0] {
    ST_INHIBIT,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OPERATING,
    ST_RAMP_STOP,
    ST_QUICK_STOP,
    ST_FAULT
  } dcw_state_type;
endpackage

// *** dcw_irq_if.sv ***
`timescale 1ns/100ps
interface dcw_irq_if;
  logic [3:0] event_set;
  logic [3:0] status_clr;
  logic [3:0] mask;
  logic [3:0] status;
  logic irq;
  modport core (output event_set, output status_clr, output mask, input status, input irq);
  modport unit (input event_set, input status_clr, input mask, output status, output irq);
endinterface

// *** dcw_sync.sv ***
`timescale 1ns/100ps
module dcw_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [W-1:0] din, // Levels from outside the clock domain.
  output logic [W-1:0] dout // Synchronised levels.
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dcw_sync_state_type;
  dcw_sync_state_type r, n;

  // The first stage feeds the second stage only.
  always_comb
  begin
    n.s1 = din;
    n.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign dout = r.s2;
endmodule

// *** dcw_irq.sv ***
`timescale 1ns/100ps
module dcw_irq (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  dcw_irq_if.unit bus // Events, clears, mask and the interrupt line.
);
  typedef struct packed {
    logic [3:0] status;
    logic irq;
  } dcw_irq_state_type;
  dcw_irq_state_type r, n;

  // A new event beats a clear in the same cycle, so nothing is lost.
  always_comb
  begin
    n.status = (r.status & ~bus.status_clr) | bus.event_set;
    n.irq = |(n.status & bus.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign bus.status = r.status;
  assign bus.irq = r.irq;
endmodule

// *** dcw_motor_model.sv ***
`timescale 1ns/100ps
module dcw_motor_model #(
  parameter int unsigned TOP_SPEED = 40
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic pulse_enable, // Output pulses on.
  input wire logic ramp_decel, // Ramp stop in progress.
  input wire logic fast_decel, // Fast stop in progress.
  output logic standstill_in, // Motor at standstill.
  output logic speed_tol_in, // Speed error within tolerance.
  output logic freq_reached_in // Frequency reached.
);
  int unsigned speed_r;
  // A fast stop sheds speed twice as quickly as a ramp, yet slowly enough that a command can land mid-stop.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      speed_r <= 0;
    else if (fast_decel)
      speed_r <= (speed_r > 2) ? speed_r - 2 : 0;
    else if (ramp_decel || !pulse_enable)
      speed_r <= (speed_r > 0) ? speed_r - 1 : 0;
    else if (speed_r < TOP_SPEED)
      speed_r <= speed_r + 1;
  end
  assign standstill_in = (speed_r == 0);
  assign speed_tol_in = (speed_r + 2 >= TOP_SPEED);
  assign freq_reached_in = (speed_r == TOP_SPEED);
endmodule

// *** test_drive_control_word_state_machine.sv ***
`timescale 1ns/100ps
module test_drive_control_word_state_machine;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, standstill_in, speed_tol_in, freq_reached_in;
  logic warning_in = 1'b0, error_in = 1'b0, error_power_off_in = 1'b0;
  logic power_enable, pulse_enable, ramp_decel, fast_decel, ramp_zero, bus_control, irq;
  logic [15:0] drive_state_word;
  logic [5:0] outs;
  int n_mismatch = 0, checks = 0;
  assign outs = {power_enable, pulse_enable, ramp_decel, fast_decel, ramp_zero, bus_control};
  always #2 pclk = ~pclk;
  dcw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standstill_in(standstill_in), .speed_tol_in(speed_tol_in), .freq_reached_in(freq_reached_in),
    .warning_in(warning_in), .error_in(error_in), .error_power_off_in(error_power_off_in),
    .power_enable(power_enable), .pulse_enable(pulse_enable), .ramp_decel(ramp_decel),
    .fast_decel(fast_decel), .ramp_zero(ramp_zero), .bus_control(bus_control),
    .drive_state_word(drive_state_word), .irq(irq));
  dcw_motor_model motor (.pclk(pclk), .presetn(presetn), .pulse_enable(pulse_enable),
    .ramp_decel(ramp_decel), .fast_decel(fast_decel), .standstill_in(standstill_in),
    .speed_tol_in(speed_tol_in), .freq_reached_in(freq_reached_in));
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Read data and the error flag are taken only at the edge where pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, q, exp);
  endtask
  task automatic cmd(input logic [15:0] d);
    apb(1'b1, dcw_pkg::OFS_CMD, {16'h0000, d});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // The motor model needs time to spin up or down, so the state word is polled under a bound.
  task automatic wsw(input logic [15:0] m, input logic [15:0] e, input string what);
    for (int i = 0; i < 300; i++)
    begin
      settle(1);
      if ((drive_state_word & m) === e)
        break;
    end
    chk(what, {16'h0000, drive_state_word & m}, {16'h0000, e});
  endtask
  task automatic run_up;
    cmd(16'h0407);
    cmd(16'h040F);
    wsw(16'hFFFF, 16'h0737, "operating word");
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    chk("reset word", {16'h0000, drive_state_word}, 32'h0000_0040);
    chk("reset outputs", 32'(outs), 32'h0000_0002);
    rd(dcw_pkg::OFS_CMD, 32'h0000_0000, "cmd reset");
    rd(dcw_pkg::OFS_LOCAL_CMD, 32'h0000_0000, "local reset");
    rd(dcw_pkg::OFS_INT_MASK, 32'h0000_0000, "mask reset");
    apb(1'b1, dcw_pkg::OFS_STATE, 32'h0000_FFFF);
    rd(dcw_pkg::OFS_STATE, 32'h0000_0040, "state read only");
    rd(8'h14, 32'h0000_0000, "unmapped data");
    chk("unmapped error", 32'(err), 32'h0000_0001);
    $display("test reset finished");
    cmd(16'h0406);
    wsw(16'hFFFF, 16'h0231, "ready word");
    cmd(16'h0407);
    wsw(16'hFFFF, 16'h0233, "switched on word");
    chk("switched on outputs", 32'(outs), 32'h0000_0023);
    cmd(16'h040F);
    wsw(16'hFFFF, 16'h0737, "operating word");
    chk("operating outputs", 32'(outs), 32'h0000_0031);
    cmd(16'h0407);
    wsw(16'h0007, 16'h0003, "disable operation");
    chk("coasting outputs", 32'(outs), 32'h0000_0023);
    $display("test power up finished");
    run_up;
    cmd(16'h040E);
    settle(2);
    chk("ramp outputs", 32'(outs), 32'h0000_0039);
    cmd(16'h040F);
    wsw(16'h0007, 16'h0007, "ramp interrupted");
    cmd(16'h040E);
    wsw(16'h0007, 16'h0001, "ramp finished");
    chk("ramp end outputs", 32'(outs), 32'h0000_0003);
    $display("test ramp stop finished");
    run_up;
    cmd(16'h040B);
    wsw(16'h0020, 16'h0000, "fast stop flag");
    cmd(16'h0409);
    settle(2);
    chk("fast stop holds", 32'({power_enable, fast_decel}), 32'h0000_0003);
    wsw(16'h0047, 16'h0040, "fast stop end");
    chk("fast stop power", 32'(power_enable), 32'h0000_0000);
    $display("test fast stop finished");
    cmd(16'h0406);
    run_up;
    cmd(16'h040D);
    settle(2);
    chk("coast power", 32'(power_enable), 32'h0000_0000);
    chk("coast word", {16'h0000, drive_state_word & 16'h0057}, 32'h0000_0040);
    cmd(16'hFF76);
    wsw(16'hFFFF, 16'h0231, "reserved bits");
    $display("test coast finished");
    apb(1'b1, dcw_pkg::OFS_LOCAL_CMD, 32'h0000_0006);
    cmd(16'h0000);
    wsw(16'hFFFF, 16'h0031, "local word");
    chk("local bus flag", 32'(bus_control), 32'h0000_0000);
    apb(1'b1, dcw_pkg::OFS_LOCAL_CMD, 32'h0000_0007);
    wsw(16'hFFFF, 16'h0033, "local switch on");
    apb(1'b1, dcw_pkg::OFS_LOCAL_CMD, 32'h0000_0006);
    cmd(16'h0406);
    wsw(16'hFFFF, 16'h0231, "bus again");
    $display("test bus select finished");
    rd(dcw_pkg::OFS_INT_STATUS, 32'h0000_0009, "stop events");
    apb(1'b1, dcw_pkg::OFS_INT_MASK, 32'h0000_0002);
    @(posedge pclk);
    warning_in <= 1'b1;
    wsw(16'h0080, 16'h0080, "warning flag");
    chk("masked irq", 32'(irq), 32'h0000_0000);
    apb(1'b1, dcw_pkg::OFS_INT_MASK, 32'h0000_0004);
    settle(2);
    chk("unmasked irq", 32'(irq), 32'h0000_0001);
    apb(1'b0, dcw_pkg::OFS_INT_STATUS, 32'h0000_0000);
    chk("warning event", 32'(q[2]), 32'h0000_0001);
    settle(3);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    @(posedge pclk);
    warning_in <= 1'b0;
    apb(1'b1, dcw_pkg::OFS_INT_MASK, 32'h0000_0002);
    $display("test interrupt finished");
    for (int p = 0; p < 2; p++)
    begin
      cmd(16'h0406);
      wsw(16'h0007, 16'h0001, "fault prepare");
      cmd(16'h0407);
      cmd(16'h048F);
      wsw(16'h0007, 16'h0007, "fault prepare run");
      @(posedge pclk);
      error_power_off_in <= p[0];
      error_in <= 1'b1;
      wsw(16'h0008, 16'h0008, "error flag");
      chk("fault irq", 32'(irq), 32'h0000_0001);
      chk("fault power", 32'({power_enable, pulse_enable}), 32'({~p[0], 1'b0}));
      @(posedge pclk);
      error_in <= 1'b0;
      settle(10);
      chk("level no reset", 32'(drive_state_word[3]), 32'h0000_0001);
      apb(1'b0, dcw_pkg::OFS_INT_STATUS, 32'h0000_0000);
      chk("fault event", 32'(q[1]), 32'h0000_0001);
      cmd(16'h040F);
      cmd(16'h048F);
      wsw(16'h004F, p[0] ? 16'h0040 : 16'h0007, "after fault reset");
      chk("irq after fault", 32'(irq), 32'h0000_0000);
    end
    $display("test fault finished");
    final_report;
  end
endmodule
